// File: hw/bsc_pkg.sv
// constants and types for the boot strap and clock control block
package bsc_pkg;
	// crystal reference and timer rates in millihertz
	localparam longint REF_MILLIHZ = 64'd14745600000;
	localparam longint TMR_FAST_MILLIHZ = 64'd508468900;
	localparam longint TMR_MID_MILLIHZ = 64'd983000000;
	localparam longint TMR_SLOW_MILLIHZ = 64'd1993900;
	localparam int TMR_FAST_DIV = int'(REF_MILLIHZ / TMR_FAST_MILLIHZ);
	localparam int TMR_MID_DIV = int'(REF_MILLIHZ / TMR_MID_MILLIHZ);
	localparam int TMR_SLOW_DIV = int'(REF_MILLIHZ / TMR_SLOW_MILLIHZ);
	localparam logic [12:0] TMR_FAST_LAST = 13'(TMR_FAST_DIV - 1);
	localparam logic [12:0] TMR_MID_LAST = 13'(TMR_MID_DIV - 1);
	// watchdog tap from the real-time-clock chain
	localparam int RTC_HZ = 32768;
	localparam int WDT_HZ = 256;
	localparam logic [6:0] WDT_HALF_LAST = 7'(RTC_HZ / WDT_HZ / 2 - 1);
	localparam logic [2:0] AAC_LAST = 3'h4;
	localparam logic [2:0] AAC_HIGH = 3'h2;
	localparam logic [1:0] AUD_BIT_HALF_LAST = 2'h1;
	localparam logic [4:0] AUD_WORD_HALF_LAST = 5'h1f;
	localparam logic [9:0] PLL_LOCK_CYCLES = 10'h3e8;
	localparam logic [31:0] BOOT_FETCH_ADDR = 32'h0000_0000;
	localparam int CS_WDT_TIMER = 1;
	localparam int CS_WDT_DURATION = 2;
	localparam int CS_WIDTH_LO = 6;
	localparam logic [1:0] PRE_DIV2 = 2'h0;
	localparam logic [1:0] PRE_DIV25 = 2'h1;
	localparam logic [1:0] PRE_DIV3 = 2'h2;

	typedef struct packed {
		logic [7:0] chip_select_lines;
		logic boot_source_strap;
		logic serial_data_strap;
		logic [1:0] boot_mode_straps;
		logic boot_sync_strap;
	} bsc_strap_t;

	typedef struct packed {
		logic serial_boot_flag;
		bsc_strap_t latched;
	} bsc_system_config_register_t;

	typedef struct packed {
		logic [3:0] usb_divider_field;
		logic [1:0] output_postscaler;
		logic [4:0] input_predivider;
		logic [5:0] second_feedback_divider;
		logic [4:0] first_feedback_divider;
	} bsc_pll_cfg_t;

	typedef struct packed {
		logic [11:0] mult;
		logic [5:0] prediv;
		logic [1:0] post_shift;
	} bsc_pll_ratio_t;

	typedef struct packed {
		logic enable;
		logic [1:0] pre_sel;
		logic [6:0] divider;
	} bsc_gen_cfg_t;

	typedef enum logic [2:0] {
		BP_NONE = 3'h0,
		BP_EXT_SYNC = 3'h1,
		BP_EXT_ASYNC = 3'h2,
		BP_INT_UART = 3'h3,
		BP_INT_SPI_TRY = 3'h4,
		BP_INT_SPI = 3'h5,
		BP_INT_SYNC = 3'h6,
		BP_INT_ASYNC = 3'h7
	} bsc_path_t;

	typedef enum logic [1:0] {
		BW_8 = 2'h0,
		BW_16 = 2'h1,
		BW_32 = 2'h2,
		BW_NA = 2'h3
	} bsc_width_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_STANDBY = 2'h1
	} bsc_pwr_t;
endpackage : bsc_pkg

// File: hw/bsc_pdiv.sv
// pre-divider of 2, 2.5 or 3 followed by a 7-bit divider
`timescale 1ns/1ps
`default_nettype none
module bsc_pdiv import bsc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire bsc_gen_cfg_t cfg,
	output logic clk_out,
	output logic rise
);
	logic [2:0] pre_cnt_r;
	logic [2:0] pre_last;
	logic pre_tick;
	logic [6:0] div_cnt_r;
	logic div_hit;

	always_comb begin
		unique case (cfg.pre_sel)
			PRE_DIV25: pre_last = 3'h4;
			PRE_DIV3: pre_last = 3'h2;
			default: pre_last = 3'h1;
		endcase
	end

	// 2.5 gives two ticks per five cycles, spaced three then two
	assign pre_tick = cfg.enable && ((pre_cnt_r == pre_last) ||
		(cfg.pre_sel == PRE_DIV25 && pre_cnt_r == 3'h2)); // see R16
	assign div_hit = pre_tick && (div_cnt_r >= cfg.divider - 7'h1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_r <= 3'h0;
		end else if (!cfg.enable || pre_cnt_r >= pre_last) begin
			pre_cnt_r <= 3'h0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end

	// divider zero holds the clock still
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_r <= 7'h0;
			clk_out <= 1'b0;
			rise <= 1'b0;
		end else begin
			rise <= 1'b0;
			if (!cfg.enable || cfg.divider == 7'h0) begin
				div_cnt_r <= 7'h0;
			end else if (div_hit) begin
				div_cnt_r <= 7'h0;
				clk_out <= !clk_out; // see R16
				rise <= !clk_out;
			end else if (pre_tick) begin
				div_cnt_r <= div_cnt_r + 7'h1;
			end
		end
	end

	property p_pre_div2;
		@(posedge clk) disable iff (!rst_n)
		(pre_tick && cfg.enable && cfg.pre_sel == PRE_DIV2 && $stable(cfg))
			|=> !pre_tick ##1 (pre_tick || cfg != $past(cfg, 2));
	endproperty
	a_pre_div2: assert property (p_pre_div2) else $error("pre-divider by two misspaced"); // see R16
endmodule : bsc_pdiv
`default_nettype wire

// File: hw/bsc_top.sv
// boot strap capture and clock generation top
// Behaviour
// R1: straps captured when power-on or user reset pin rises.
// R2: captured straps held in system config register, readable by software.
// R3: chip-select 1 strap enables watchdog timer, chip-select 2 its duration.
// R4: external sync boot from SDRAM select three; width 16 or 32.
// R5: external async boot from static select zero; width 8, 16, 32, 32.
// R6: internal boot over first serial port, sync and width ignored.
// R7: internal mode 00 tries serial flash first, taken only with signature.
// R8: otherwise sync internal boot at signature select; width 16 or 32.
// R9: otherwise async internal boot at signature select; width 8, 16, 32, 32.
// R10: serial boot is normal boot plus a readable serial-boot flag.
// R11: first fetch at address zero, mapped to the chosen boot memory.
// R12: two identical independent PLLs on crystal, followed by dividers.
// R13: PLL output is ref times feedback products over predivider and postscaler.
// R14: software keeps PLL reference and output frequencies within their ranges.
// R15: software keeps cpu, AHB, APB clock limits and their ordering.
// R16: audio, video, infrared generators: pre-divide 2, 2.5, 3, then 7-bit.
// R17: audio bit and word clocks divided from the audio master clock.
// R18: USB 48 MHz clock from second PLL through the USB divider field.
// R19: crystal chain gives divide 2..64; keypad and touch pick 4 or 16.
// R20: serial port at crystal/2, AC-link at crystal/5, PWM at crystal.
// R21: timer clocks about 508.4689 kHz, 1.9939 kHz and 983 kHz from crystal.
// R22: watchdog clock 256 Hz tapped from the 32 kHz RTC chain.
// R23: first PLL write forces standby until settings settle, then back to run.
`timescale 1ns/1ps
`default_nettype none
module bsc_top import bsc_pkg::*; #(
	parameter int TMR_SLOW_COUNT = TMR_SLOW_DIV
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic power_on_reset_pin_n,
	input wire logic user_reset_pin_n,
	input wire bsc_strap_t strap_in,
	input wire logic spi_probe_done,
	input wire logic spi_signature_found,
	input wire logic pll1_write,
	input wire bsc_pll_cfg_t pll1_settings,
	input wire logic pll2_write,
	input wire bsc_pll_cfg_t pll2_settings,
	input wire bsc_gen_cfg_t audio_cfg,
	input wire bsc_gen_cfg_t video_cfg,
	input wire bsc_gen_cfg_t infrared_cfg,
	input wire logic keypad_sel_div16,
	input wire logic touch_sel_div16,
	input wire logic rtc_tick,
	output bsc_system_config_register_t system_config_register,
	output logic watchdog_timer_enable,
	output logic watchdog_duration_enable,
	output bsc_path_t boot_path,
	output bsc_width_t boot_width,
	output logic [31:0] boot_fetch_address,
	output bsc_pll_ratio_t pll1_ratio,
	output bsc_pll_ratio_t pll2_ratio,
	output logic [4:0] usb_divide_ratio,
	output logic standby,
	output logic audio_master_clk,
	output logic audio_bit_clk,
	output logic audio_word_clk,
	output logic video_pixel_clock,
	output logic infrared_clock,
	output logic [5:0] xtal_div,
	output logic keypad_clk,
	output logic touch_clk,
	output logic ssp_clk,
	output logic aac_clk,
	output logic pwm_clk_en,
	output logic tmr_fast_tick,
	output logic tmr_mid_tick,
	output logic tmr_slow_tick,
	output logic wdt_clk
);
	localparam logic [12:0] TMR_SLOW_LAST = 13'(TMR_SLOW_COUNT - 1);

	logic rst_sync1_r;
	logic rst_sync2_r;
	logic rst_n;
	logic por_n_r;
	logic usr_n_r;
	logic capture;
	bsc_system_config_register_t system_config_register_r;
	bsc_path_t path_r;
	bsc_width_t width_r;
	bsc_pwr_t pwr_r;
	logic [9:0] lock_cnt_r;
	logic aud_rise;
	logic [1:0] bit_cnt_r;
	logic bit_rise;
	logic [4:0] word_cnt_r;
	logic [2:0] aac_cnt_r;
	logic [12:0] tf_cnt_r;
	logic [12:0] tm_cnt_r;
	logic [12:0] ts_cnt_r;
	logic [6:0] wdt_cnt_r;

	function automatic bsc_width_t decode_width(input logic sync, input logic [1:0] code);
		if (code[1]) begin
			decode_width = BW_32;
		end else if (sync || code[0]) begin
			decode_width = BW_16;
		end else begin
			decode_width = BW_8;
		end
	endfunction : decode_width

	function automatic bsc_path_t decode_path(input bsc_strap_t s);
		decode_path = BP_NONE;
		if (s.serial_data_strap && !s.boot_mode_straps[1]) begin
			if (!s.boot_source_strap) begin
				if (!s.boot_mode_straps[0]) begin
					decode_path = s.boot_sync_strap ? BP_EXT_SYNC : BP_EXT_ASYNC;
				end
			end else if (s.boot_mode_straps[0]) begin
				decode_path = BP_INT_UART;
			end else begin
				decode_path = BP_INT_SPI_TRY;
			end
		end
	endfunction : decode_path

	function automatic bsc_pll_ratio_t pll_ratio(input bsc_pll_cfg_t c);
		logic [11:0] a;
		logic [11:0] b;
		a = {7'h0, c.first_feedback_divider} + 12'h1;
		b = {6'h0, c.second_feedback_divider} + 12'h1;
		pll_ratio.mult = 12'(a * b);
		pll_ratio.prediv = {1'b0, c.input_predivider} + 6'h1;
		pll_ratio.post_shift = c.output_postscaler;
	endfunction : pll_ratio

	function automatic logic [12:0] wrap_inc(input logic [12:0] c, input logic [12:0] last);
		wrap_inc = (c >= last) ? 13'h0 : c + 13'h1;
	endfunction : wrap_inc

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end
	assign rst_n = rst_sync2_r;

	// pins start as held so a high pin after reset counts as a release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_n_r <= 1'b0;
			usr_n_r <= 1'b0;
		end else begin
			por_n_r <= power_on_reset_pin_n;
			usr_n_r <= user_reset_pin_n;
		end
	end
	assign capture = (power_on_reset_pin_n && !por_n_r) || (user_reset_pin_n && !usr_n_r); // see R1

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			system_config_register_r <= '0;
		end else if (capture) begin
			system_config_register_r.latched <= strap_in; // see R1, R2
			system_config_register_r.serial_boot_flag <= (decode_path(strap_in) == BP_INT_UART); // see R10
		end
	end
	assign system_config_register = system_config_register_r;
	assign watchdog_timer_enable = system_config_register_r.latched.chip_select_lines[CS_WDT_TIMER]; // see R3
	assign watchdog_duration_enable = system_config_register_r.latched.chip_select_lines[CS_WDT_DURATION]; // see R3

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			path_r <= BP_NONE;
			width_r <= BW_NA;
		end else if (capture) begin
			path_r <= decode_path(strap_in); // see R4, R5, R6
			if (decode_path(strap_in) == BP_INT_UART || decode_path(strap_in) == BP_NONE) begin
				width_r <= BW_NA; // see R6
			end else begin
				width_r <= decode_width(strap_in.boot_sync_strap,
					strap_in.chip_select_lines[CS_WIDTH_LO +: 2]); // see R4, R5, R8, R9
			end
		end else if (path_r == BP_INT_SPI_TRY && spi_probe_done) begin
			if (spi_signature_found) begin
				path_r <= BP_INT_SPI; // see R7
			end else if (system_config_register_r.latched.boot_sync_strap) begin
				path_r <= BP_INT_SYNC; // see R8
			end else begin
				path_r <= BP_INT_ASYNC; // see R9
			end
		end
	end
	assign boot_path = path_r;
	assign boot_width = width_r;
	assign boot_fetch_address = BOOT_FETCH_ADDR; // see R11

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll1_ratio <= '0;
		end else if (pll1_write) begin
			pll1_ratio <= pll_ratio(pll1_settings); // see R12, R13
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll2_ratio <= '0;
			usb_divide_ratio <= 5'h1;
		end else if (pll2_write) begin
			pll2_ratio <= pll_ratio(pll2_settings); // see R12, R13
			usb_divide_ratio <= {1'b0, pll2_settings.usb_divider_field} + 5'h1; // see R18
		end
	end

	// a new write while settling restarts the wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r <= ST_RUN;
			lock_cnt_r <= 10'h0;
		end else if (pll1_write) begin
			pwr_r <= ST_STANDBY; // see R23
			lock_cnt_r <= PLL_LOCK_CYCLES;
		end else begin
			unique case (pwr_r)
				ST_RUN: begin
					lock_cnt_r <= 10'h0;
				end
				ST_STANDBY: begin
					lock_cnt_r <= lock_cnt_r - 10'h1;
					if (lock_cnt_r == 10'h1) begin
						pwr_r <= ST_RUN; // see R23
					end
				end
			endcase
		end
	end
	assign standby = (pwr_r == ST_STANDBY);

	bsc_pdiv u_audio (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(audio_cfg),
		.clk_out(audio_master_clk),
		.rise(aud_rise)
	);

	bsc_pdiv u_video (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(video_cfg),
		.clk_out(video_pixel_clock),
		.rise()
	);

	bsc_pdiv u_infrared (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(infrared_cfg),
		.clk_out(infrared_clock),
		.rise()
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= 2'h0;
			audio_bit_clk <= 1'b0;
			bit_rise <= 1'b0;
		end else begin
			bit_rise <= 1'b0;
			if (aud_rise) begin
				if (bit_cnt_r == AUD_BIT_HALF_LAST) begin
					bit_cnt_r <= 2'h0;
					audio_bit_clk <= !audio_bit_clk; // see R17
					bit_rise <= !audio_bit_clk;
				end else begin
					bit_cnt_r <= bit_cnt_r + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word_cnt_r <= 5'h0;
			audio_word_clk <= 1'b0;
		end else if (bit_rise) begin
			if (word_cnt_r == AUD_WORD_HALF_LAST) begin
				word_cnt_r <= 5'h0;
				audio_word_clk <= !audio_word_clk; // see R17
			end else begin
				word_cnt_r <= word_cnt_r + 5'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_div <= 6'h0;
		end else begin
			xtal_div <= xtal_div + 6'h1; // see R19
		end
	end
	assign ssp_clk = xtal_div[0]; // see R20

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keypad_clk <= 1'b0;
			touch_clk <= 1'b0;
		end else begin
			keypad_clk <= keypad_sel_div16 ? xtal_div[3] : xtal_div[1]; // see R19
			touch_clk <= touch_sel_div16 ? xtal_div[3] : xtal_div[1]; // see R19
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aac_cnt_r <= 3'h0;
			aac_clk <= 1'b0;
			pwm_clk_en <= 1'b0;
		end else begin
			aac_cnt_r <= (aac_cnt_r == AAC_LAST) ? 3'h0 : aac_cnt_r + 3'h1;
			aac_clk <= (aac_cnt_r < AAC_HIGH); // see R20
			pwm_clk_en <= 1'b1; // see R20
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tf_cnt_r <= 13'h0;
			tm_cnt_r <= 13'h0;
			ts_cnt_r <= 13'h0;
			tmr_fast_tick <= 1'b0;
			tmr_mid_tick <= 1'b0;
			tmr_slow_tick <= 1'b0;
		end else begin
			tf_cnt_r <= wrap_inc(tf_cnt_r, TMR_FAST_LAST); // see R21
			tm_cnt_r <= wrap_inc(tm_cnt_r, TMR_MID_LAST);
			ts_cnt_r <= wrap_inc(ts_cnt_r, TMR_SLOW_LAST);
			tmr_fast_tick <= (tf_cnt_r == TMR_FAST_LAST);
			tmr_mid_tick <= (tm_cnt_r == TMR_MID_LAST);
			tmr_slow_tick <= (ts_cnt_r == TMR_SLOW_LAST);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_cnt_r <= 7'h0;
			wdt_clk <= 1'b0;
		end else if (rtc_tick) begin
			if (wdt_cnt_r == WDT_HALF_LAST) begin
				wdt_cnt_r <= 7'h0;
				wdt_clk <= !wdt_clk; // see R22
			end else begin
				wdt_cnt_r <= wdt_cnt_r + 7'h1;
			end
		end
	end

	property p_capture;
		@(posedge clk) disable iff (!rst_n)
		capture |=> system_config_register.latched == $past(strap_in);
	endproperty
	a_capture: assert property (p_capture) else $error("straps not latched on reset release"); // see R1, R2

	property p_wdt;
		@(posedge clk) disable iff (!rst_n)
		capture |=> watchdog_timer_enable == $past(strap_in.chip_select_lines[1])
			&& watchdog_duration_enable == $past(strap_in.chip_select_lines[2]);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog straps wrong"); // see R3

	property p_ext_sync;
		@(posedge clk) disable iff (!rst_n)
		(capture && strap_in[4:0] == 5'b01001 && strap_in.chip_select_lines[7:6] == 2'b01)
			|=> boot_path == BP_EXT_SYNC && boot_width == BW_16;
	endproperty
	a_ext_sync: assert property (p_ext_sync) else $error("external sync boot misdecoded"); // see R4

	property p_ext_async;
		@(posedge clk) disable iff (!rst_n)
		(capture && strap_in[4:0] == 5'b01000 && strap_in.chip_select_lines[7:6] == 2'b00)
			|=> boot_path == BP_EXT_ASYNC && boot_width == BW_8;
	endproperty
	a_ext_async: assert property (p_ext_async) else $error("external async boot misdecoded"); // see R5

	property p_uart;
		@(posedge clk) disable iff (!rst_n)
		(capture && strap_in[4:1] == 4'b1101)
			|=> boot_path == BP_INT_UART && system_config_register.serial_boot_flag;
	endproperty
	a_uart: assert property (p_uart) else $error("serial port boot misdecoded"); // see R6, R10

	property p_spi;
		@(posedge clk) disable iff (!rst_n)
		(!capture && boot_path == BP_INT_SPI_TRY && spi_probe_done)
			|=> boot_path == ($past(spi_signature_found) ? BP_INT_SPI :
				system_config_register.latched.boot_sync_strap ? BP_INT_SYNC : BP_INT_ASYNC);
	endproperty
	a_spi: assert property (p_spi) else $error("serial flash fallback wrong"); // see R7, R8, R9

	property p_pll;
		@(posedge clk) disable iff (!rst_n)
		pll1_write |=> pll1_ratio.mult == 12'(({7'h0, $past(pll1_settings.first_feedback_divider)} + 12'h1)
			* ({6'h0, $past(pll1_settings.second_feedback_divider)} + 12'h1));
	endproperty
	a_pll: assert property (p_pll) else $error("pll ratio wrong"); // see R13

	// cycles of standby since the last settings write
	logic [10:0] stby_seen_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stby_seen_r <= 11'h0;
		end else if (pll1_write || !standby) begin
			stby_seen_r <= 11'h0;
		end else if (stby_seen_r != 11'h7ff) begin
			stby_seen_r <= stby_seen_r + 11'h1;
		end
	end

	property p_standby;
		@(posedge clk) disable iff (!rst_n)
		pll1_write |=> standby[*8];
	endproperty
	a_standby: assert property (p_standby) else $error("standby after pll write wrong"); // see R23

	property p_stby_len;
		@(posedge clk) disable iff (!rst_n)
		(stby_seen_r <= {1'b0, PLL_LOCK_CYCLES}) and ($fell(standby) |-> stby_seen_r == {1'b0, PLL_LOCK_CYCLES});
	endproperty
	a_stby_len: assert property (p_stby_len) else $error("standby length wrong"); // see R23

	property p_fast_tmr;
		@(posedge clk) disable iff (!rst_n)
		tmr_fast_tick |=> !tmr_fast_tick[*8];
	endproperty
	a_fast_tmr: assert property (p_fast_tmr) else $error("timer tick too frequent"); // see R21

	property p_keypad;
		@(posedge clk) disable iff (!rst_n)
		!$past(keypad_sel_div16) |-> keypad_clk == $past(xtal_div[1]);
	endproperty
	a_keypad: assert property (p_keypad) else $error("keypad clock source wrong"); // see R19

	c_ext_sync: cover property (@(posedge clk) disable iff (!rst_n) boot_path == BP_EXT_SYNC);
	c_uart: cover property (@(posedge clk) disable iff (!rst_n) boot_path == BP_INT_UART);
	c_spi: cover property (@(posedge clk) disable iff (!rst_n) boot_path == BP_INT_SPI);
	c_standby: cover property (@(posedge clk) disable iff (!rst_n) $fell(standby));
endmodule : bsc_top
`default_nettype wire

// File: dv/bsc_board_model.sv
// board model: strap pins with pull-ups and the two reset pins
`timescale 1ns/1ps
`default_nettype none
module bsc_board_model import bsc_pkg::*; (
	input wire logic clk,
	output logic power_on_reset_pin_n,
	output logic user_reset_pin_n,
	output bsc_strap_t strap_in
);
	initial begin
		power_on_reset_pin_n = 1'b0;
		user_reset_pin_n = 1'b0;
		strap_in = 13'h0a5a;
	end

	// pulse one reset pin with the straps set up, then let the straps go
	task automatic apply(input logic use_user, input bsc_strap_t s);
		@(negedge clk);
		strap_in = s;
		if (use_user) begin
			user_reset_pin_n = 1'b0;
		end else begin
			power_on_reset_pin_n = 1'b0;
		end
		repeat (4) @(negedge clk);
		if (use_user) begin
			user_reset_pin_n = 1'b1;
		end else begin
			power_on_reset_pin_n = 1'b1;
		end
		repeat (2) @(negedge clk);
		// released lines: pulled-up ones go high, the rest show the inverse
		strap_in = ~s;
		strap_in.chip_select_lines[3] = 1'b1;
		strap_in.boot_source_strap = 1'b1;
		strap_in.serial_data_strap = 1'b1;
	endtask : apply
endmodule : bsc_board_model
`default_nettype wire

// File: dv/tb_boot_strap_and_clock_control.sv
// self-checking bench for strap capture, boot decode and clock generation
`timescale 1ns/1ps
`default_nettype none
module tb_boot_strap_and_clock_control import bsc_pkg::*; ();
	logic clk, rstn, spi_probe_done, spi_signature_found, pll1_write, pll2_write;
	logic keypad_sel_div16, touch_sel_div16, rtc_tick, power_on_reset_pin_n, user_reset_pin_n;
	bsc_strap_t strap_in;
	bsc_pll_cfg_t pll1_settings, pll2_settings;
	bsc_gen_cfg_t audio_cfg, video_cfg, infrared_cfg;
	bsc_system_config_register_t system_config_register;
	logic watchdog_timer_enable, watchdog_duration_enable, standby, audio_master_clk, audio_bit_clk;
	logic audio_word_clk, video_pixel_clock, infrared_clock, keypad_clk, touch_clk, ssp_clk, aac_clk;
	logic pwm_clk_en, tmr_fast_tick, tmr_mid_tick, tmr_slow_tick, wdt_clk;
	bsc_path_t boot_path;
	bsc_width_t boot_width;
	logic [31:0] boot_fetch_address;
	bsc_pll_ratio_t pll1_ratio, pll2_ratio;
	logic [4:0] usb_divide_ratio;
	logic [5:0] xtal_div;
	logic [18:0] clks;
	int cyc = 0;
	int rtc_cnt = 0;
	int err_total = 0;
	int cmp_count = 0;

	assign clks = {wdt_clk, tmr_slow_tick, tmr_mid_tick, tmr_fast_tick, aac_clk, ssp_clk, touch_clk, keypad_clk,
		infrared_clock, video_pixel_clock, audio_word_clk, audio_bit_clk, audio_master_clk, xtal_div};

	bsc_top #(.TMR_SLOW_COUNT(20)) dut_u (.clk, .rstn, .power_on_reset_pin_n, .user_reset_pin_n, .strap_in,
		.spi_probe_done, .spi_signature_found, .pll1_write, .pll1_settings, .pll2_write, .pll2_settings,
		.audio_cfg, .video_cfg, .infrared_cfg, .keypad_sel_div16, .touch_sel_div16, .rtc_tick,
		.system_config_register, .watchdog_timer_enable, .watchdog_duration_enable, .boot_path, .boot_width,
		.boot_fetch_address, .pll1_ratio, .pll2_ratio, .usb_divide_ratio, .standby, .audio_master_clk,
		.audio_bit_clk, .audio_word_clk, .video_pixel_clock, .infrared_clock, .xtal_div, .keypad_clk,
		.touch_clk, .ssp_clk, .aac_clk, .pwm_clk_en, .tmr_fast_tick, .tmr_mid_tick, .tmr_slow_tick, .wdt_clk);

	bsc_board_model board_u (.clk, .power_on_reset_pin_n, .user_reset_pin_n, .strap_in);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			err_total = err_total + 1;
			test_done();
		end
	end

	// rtc tick once every four cycles
	always @(negedge clk) begin
		rtc_cnt <= rtc_cnt + 1;
		rtc_tick <= (rtc_cnt[1:0] == 2'h3);
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic bsc_width_t exp_w(input bsc_strap_t s);
		if (s.boot_sync_strap) return s.chip_select_lines[7] ? BW_32 : BW_16;
		return s.chip_select_lines[7] ? BW_32 : (s.chip_select_lines[6] ? BW_16 : BW_8);
	endfunction : exp_w

	task automatic check_cap(input bsc_strap_t s, input bsc_path_t p, input bsc_width_t w, input logic flag,
		input logic chkw);
		chk(system_config_register, {flag, s});
		chk(watchdog_timer_enable, s.chip_select_lines[1]);
		chk(watchdog_duration_enable, s.chip_select_lines[2]);
		chk(boot_path, p);
		if (chkw) chk(boot_width, w);
		chk(boot_fetch_address, 32'h0000_0000);
	endtask : check_cap

	// period in cycles between the 2nd and 3rd rising edge of one output
	task automatic meas(input int idx, input int exp);
		int n, k, g;
		logic prev;
		n = 0;
		k = 0;
		prev = clks[idx];
		for (g = 0; g < 20000 && k < 3; g++) begin
			@(negedge clk);
			n++;
			if (clks[idx] === 1'b1 && prev === 1'b0) begin
				k++;
				if (k == 2) n = 0;
			end
			prev = clks[idx];
		end
		chk(n, exp);
	endtask : meas

	// caller has just raised pll1_write at this negedge
	task automatic stby_count(output int n);
		n = 0;
		for (int g = 0; g < 1200; g++) begin
			@(negedge clk);
			pll1_write = 1'b0;
			if (standby === 1'b1) n++;
			else if (n > 0) break;
		end
	endtask : stby_count

	initial begin
		bsc_strap_t s;
		bsc_path_t p;
		int n;
		rstn = 1'b0;
		{spi_probe_done, spi_signature_found, pll1_write, pll2_write, keypad_sel_div16, touch_sel_div16} = 6'h00;
		pll1_settings = '0;
		pll2_settings = '0;
		audio_cfg = {1'b1, PRE_DIV2, 7'h04};
		video_cfg = {1'b1, PRE_DIV25, 7'h06};
		infrared_cfg = {1'b1, PRE_DIV3, 7'h02};
		repeat (10) @(negedge clk);
		chk(boot_width, BW_NA);
		chk(usb_divide_ratio, 5'h01);
		chk(boot_path, BP_NONE);
		chk(standby, 1'b0);
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		// every width and sync code, both pins, both probe outcomes
		for (int i = 0; i < 32; i++) begin
			s = {i[2:1], 3'b101, i[0], ~i[0], 1'b0, i[4], 1'b1, 2'h0, i[3]};
			board_u.apply(i[0], s);
			repeat (2) @(negedge clk);
			p = i[4] ? BP_INT_SPI_TRY : (i[3] ? BP_EXT_SYNC : BP_EXT_ASYNC);
			check_cap(s, p, exp_w(s), 1'b0, 1'b1);
			spi_probe_done = 1'b1;
			spi_signature_found = i[1];
			@(negedge clk);
			spi_probe_done = 1'b0;
			@(negedge clk);
			if (i[4]) p = i[1] ? BP_INT_SPI : (i[3] ? BP_INT_SYNC : BP_INT_ASYNC);
			chk(boot_path, p);
			chk(boot_width, exp_w(s));
		end
		for (int i = 0; i < 2; i++) begin
			s = {8'h4e, 1'b1, 1'b1, 2'h1, i[0]};
			board_u.apply(i[0], s);
			repeat (2) @(negedge clk);
			check_cap(s, BP_INT_UART, BW_NA, 1'b1, 1'b0);
		end
		s = {8'h8a, 1'b0, 1'b0, 2'h0, 1'b1};
		board_u.apply(1'b0, s);
		repeat (2) @(negedge clk);
		check_cap(s, BP_NONE, BW_NA, 1'b0, 1'b1);
		// legal multiplier settings only
		@(negedge clk);
		pll1_settings = {4'h0, 2'h1, 5'h01, 6'h02, 5'h13};
		pll1_write = 1'b1;
		stby_count(n);
		chk(n, 1000);
		chk(pll1_ratio, {12'h03c, 6'h02, 2'h1});
		@(negedge clk);
		pll1_write = 1'b1;
		@(negedge clk);
		pll1_write = 1'b0;
		repeat (499) @(negedge clk);
		chk(standby, 1'b1);
		pll1_write = 1'b1;
		stby_count(n);
		chk(n, 1000);
		pll2_settings = {4'h9, 2'h0, 5'h02, 6'h03, 5'h17};
		pll2_write = 1'b1;
		@(negedge clk);
		pll2_write = 1'b0;
		repeat (2) @(negedge clk);
		chk(pll2_ratio, {12'h060, 6'h03, 2'h0});
		chk(usb_divide_ratio, 5'h0a);
		chk(pll1_ratio, {12'h03c, 6'h02, 2'h1});
		chk(standby, 1'b0);
		for (int k = 0; k < 4; k++) begin
			audio_cfg = {1'b1, k[1:0], 7'h04};
			meas(6, (k == 1) ? 20 : ((k == 2) ? 24 : 16));
		end
		audio_cfg = {1'b1, PRE_DIV2, 7'h04};
		meas(7, 64);
		meas(8, 4096);
		meas(9, 30);
		meas(10, 12);
		for (int k = 0; k < 6; k++) meas(k, 2 << k);
		meas(11, 4);
		keypad_sel_div16 = 1'b1;
		meas(11, 16);
		meas(12, 4);
		touch_sel_div16 = 1'b1;
		meas(12, 16);
		meas(13, 2);
		meas(14, 5);
		chk(pwm_clk_en, 1'b1);
		meas(15, TMR_FAST_DIV);
		meas(16, TMR_MID_DIV);
		meas(17, 20);
		meas(18, 512);
		test_done();
	end
endmodule : tb_boot_strap_and_clock_control
`default_nettype wire
